// File: design/adc_timer_trigger_slots.sv
`timescale 1ns/100ps
// Operation
// - a timer trigger event starts the timer-triggered conversion sequence
// - twelve 8-bit slots, numbered 0 to 11, four per 32-bit word
// - a slot converts only when its enable bit is one, else skipped
// - 5-bit channel code selects inputs 0 to 17; higher codes reserved
// - result of slot m goes to conversion result register m
// - completion of the sequence raises the conversion-done interrupt
// - first word: slots 3..0, enable at byte bit 7, channel at bits 4-0
// - second word holds slots 7..4; gap bits read zero; all reset zero
// - third word holds slots 11..8 in the same byte positions
module adc_timer_trigger_slots (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_trigger_event,
  output logic             conv_start,
  output logic      [4:0]  analog_input,
  output logic      [3:0]  conversion_result_slot,
  input  wire logic        conv_complete,
  output logic             timer_conversion_done_irq,
  output logic             irq
);
  logic [31:0] slot_word [3];
  logic [adc_trig_pkg::num_slots-1:0] enables;
  logic [4:0] chans [adc_trig_pkg::num_slots];
  logic [adc_trig_pkg::irq_w-1:0] irq_mask;
  logic [adc_trig_pkg::irq_w-1:0] irq_status;
  adc_trig_pkg::seq_state_t state;
  logic [adc_trig_pkg::slot_idx_w-1:0] cur_slot;
  logic       pick_found;
  logic [3:0] pick_index;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic       done_evt;
  logic       bad_evt;
  logic       trig_pending;
  logic [adc_trig_pkg::slot_idx_w-1:0] scan_start;
  logic [adc_trig_pkg::irq_w-1:0] next_irq_mask;
  logic [adc_trig_pkg::irq_w-1:0] next_irq_status;

  // access phase of an apb transfer; slave answers with no wait state
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && penable && !pwrite && clk_en;
  assign addr_ok = (paddr == adc_trig_pkg::off_word_0_3) ||
                   (paddr == adc_trig_pkg::off_word_4_7) ||
                   (paddr == adc_trig_pkg::off_word_8_11) ||
                   (paddr == adc_trig_pkg::off_status) ||
                   (paddr == adc_trig_pkg::off_irq_mask) ||
                   (paddr == adc_trig_pkg::off_irq_status);

  // slot fields unpacked, one generate entry per slot
  // twelve slot bytes
  genvar g;
  generate
    for (g = 0; g < adc_trig_pkg::num_slots; g++) begin : g_slot
      localparam int w = g / adc_trig_pkg::slots_per_word;
      localparam int b = (g % adc_trig_pkg::slots_per_word) * adc_trig_pkg::slot_bits;
      assign enables[g] = slot_word[w][b + adc_trig_pkg::en_pos];
      assign chans[g]   = slot_word[w][b +: adc_trig_pkg::chan_width];
    end
  endgenerate

  // slot word storage, reserved bits masked on write
  // layout of all three slot words
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slot_word[0] <= adc_trig_pkg::word_reset;
      slot_word[1] <= adc_trig_pkg::word_reset;
      slot_word[2] <= adc_trig_pkg::word_reset;
    end else if (wr_en) begin
      if (paddr == adc_trig_pkg::off_word_0_3)
        slot_word[0] <= pwdata & {4{adc_trig_pkg::slot_rw_mask}};
      if (paddr == adc_trig_pkg::off_word_4_7)
        slot_word[1] <= pwdata & {4{adc_trig_pkg::slot_rw_mask}};
      if (paddr == adc_trig_pkg::off_word_8_11)
        slot_word[2] <= pwdata & {4{adc_trig_pkg::slot_rw_mask}};
    end
  end

  // interrupt mask; a one lets its status bit reach the interrupt line
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_en && paddr == adc_trig_pkg::off_irq_mask) begin
      next_irq_mask = pwdata[adc_trig_pkg::irq_w-1:0];
    end
  end

  // mask register, frozen with the clock enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask <= '0;
    end else if (clk_en) begin
      irq_mask <= next_irq_mask;
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    next_irq_status = irq_status;
    for (int i = 0; i < adc_trig_pkg::irq_w; i++) begin
      if ((i == adc_trig_pkg::irq_done_bit && done_evt) ||
          (i == adc_trig_pkg::irq_bad_bit && bad_evt)) begin
        next_irq_status[i] = 1'b1;
      end else if (wr_en && paddr == adc_trig_pkg::off_irq_status && pwdata[i]) begin
        next_irq_status[i] = 1'b0;
      end
    end
  end

  // status register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
    end
  end

  // level interrupt from next status and mask, so it never lags a write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // apb read data and error response, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          adc_trig_pkg::off_word_0_3:   prdata <= slot_word[0];
          adc_trig_pkg::off_word_4_7:   prdata <= slot_word[1];
          adc_trig_pkg::off_word_8_11:  prdata <= slot_word[2];
          adc_trig_pkg::off_status:     prdata <= {26'h0, cur_slot, state};
          adc_trig_pkg::off_irq_mask:   prdata <= {30'h0, irq_mask};
          adc_trig_pkg::off_irq_status: prdata <= {30'h0, irq_status};
          default:                      prdata <= '0;
        endcase
      end
    end
  end

  // next enabled slot finder
  assign scan_start = (state == adc_trig_pkg::st_idle) ? '0 : cur_slot;
  slot_pick u_pick (
    .enables (enables),
    .start   (scan_start),
    .found   (pick_found),
    .index   (pick_index)
  );

  // a trigger arriving mid-sequence is held and run afterwards;
  // only one is held, so further triggers in the same run merge into it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trig_pending <= 1'b0;
    end else if (clk_en) begin
      if (timer_trigger_event && state != adc_trig_pkg::st_idle)
        trig_pending <= 1'b1;
      else if (state == adc_trig_pkg::st_idle)
        trig_pending <= 1'b0;
    end
  end

  assign done_evt = clk_en && (state == adc_trig_pkg::st_done);
  // reserved channel code seen at conversion start
  assign bad_evt  = clk_en && (state == adc_trig_pkg::st_scan) && pick_found &&
                    (chans[pick_index] > adc_trig_pkg::chan_max);

  // conversion sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state        <= adc_trig_pkg::st_idle;
      cur_slot     <= '0;
      conv_start   <= 1'b0;
      analog_input <= '0;
      conversion_result_slot <= '0;
      timer_conversion_done_irq <= 1'b0;
    end else if (clk_en) begin
      conv_start <= 1'b0;
      timer_conversion_done_irq <= 1'b0;
      unique case (state)
        adc_trig_pkg::st_idle: begin
          if (timer_trigger_event || trig_pending) begin
            state    <= adc_trig_pkg::st_scan;
            cur_slot <= '0;
          end
        end
        adc_trig_pkg::st_scan: begin
          if (pick_found) begin
            conv_start   <= 1'b1;
            analog_input <= chans[pick_index];
            conversion_result_slot <= pick_index;
            cur_slot     <= pick_index;
            state        <= adc_trig_pkg::st_conv;
          end else begin
            state <= adc_trig_pkg::st_done;
          end
        end
        adc_trig_pkg::st_conv: begin
          if (conv_complete) begin
            if (cur_slot == adc_trig_pkg::last_slot) begin
              state <= adc_trig_pkg::st_done;
            end else begin
              cur_slot <= cur_slot + 4'h1;
              state    <= adc_trig_pkg::st_scan;
            end
          end
        end
        adc_trig_pkg::st_done: begin
          timer_conversion_done_irq <= 1'b1;
          state <= adc_trig_pkg::st_idle;
        end
      endcase
    end
  end

  a_trigger_starts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state == adc_trig_pkg::st_idle && timer_trigger_event) |=>
    state == adc_trig_pkg::st_scan)
    else $error("trigger did not start the sequence");

  // a held trigger runs once the sequencer is idle again
  a_pending_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state == adc_trig_pkg::st_idle && trig_pending) |=>
    state == adc_trig_pkg::st_scan)
    else $error("held trigger was not run");

  // the held trigger is dropped once it has been taken
  a_pending_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state == adc_trig_pkg::st_idle) |=> !trig_pending)
    else $error("held trigger not cleared");

  // a low clock enable holds sequencer and registers
  a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(state) && $stable(cur_slot) && $stable(irq_status) &&
    $stable(slot_word[0]))
    else $error("state moved while clock enable low");

  // a started conversion is for an enabled slot
  a_enabled_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_start |-> enables[conversion_result_slot])
    else $error("conversion started on disabled slot");

  // one start pulse per converted slot
  a_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && conv_start) |=> !conv_start)
    else $error("start pulse longer than one cycle");

  a_channel_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_start |-> analog_input == chans[conversion_result_slot])
    else $error("channel differs from slot field");

  // a reserved channel code raises its status flag
  a_bad_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bad_evt |=> irq_status[adc_trig_pkg::irq_bad_bit])
    else $error("reserved code flag not set");

  // result index equals the converting slot
  a_result_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_start |-> conversion_result_slot == cur_slot)
    else $error("result index differs from slot");

  // done state raises the interrupt next cycle
  sequence s_done_state;
    clk_en && state == adc_trig_pkg::st_done;
  endsequence
  a_done_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_done_state |=> timer_conversion_done_irq ##1 !timer_conversion_done_irq)
    else $error("done interrupt pulse wrong");

  // completion sets the sticky done flag
  a_done_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_evt |=> irq_status[adc_trig_pkg::irq_done_bit])
    else $error("done flag not set");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == |(irq_status & irq_mask))
    else $error("interrupt line differs from status");

  a_slot_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cur_slot <= adc_trig_pkg::last_slot)
    else $error("slot index out of range");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((slot_word[0] | slot_word[1] | slot_word[2]) &
     ~{4{adc_trig_pkg::slot_rw_mask}}) == 32'h0)
    else $error("reserved slot bits set");

  a_write_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && paddr == adc_trig_pkg::off_word_8_11) |=>
    slot_word[2] == ($past(pwdata) & {4{adc_trig_pkg::slot_rw_mask}}))
    else $error("slot word did not store write");

  // unmapped place answers with an error and zero data
  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && psel && !penable && !addr_ok) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // ready stands for the access cycle only
  a_pready_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pready) |=> !pready)
    else $error("ready longer than one cycle");

  // enable of slot 3 lands at bit 31 of the first word
  a_slot3_layout: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && paddr == adc_trig_pkg::off_word_0_3) |=> enables[3] == $past(pwdata[31]))
    else $error("slot 3 enable misplaced");

  // slot 11 channel lands at bits 28-24 of the third word
  a_slot11_layout: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && paddr == adc_trig_pkg::off_word_8_11) |=> chans[11] == $past(pwdata[28:24]))
    else $error("slot 11 channel misplaced");
endmodule

// File: design/adc_trig_pkg.sv
package adc_trig_pkg;
  // register byte offsets
  localparam logic [11:0] off_word_0_3   = 12'h000;
  localparam logic [11:0] off_word_4_7   = 12'h004;
  localparam logic [11:0] off_word_8_11  = 12'h008;
  localparam logic [11:0] off_status     = 12'h00c;
  localparam logic [11:0] off_irq_mask   = 12'h010;
  localparam logic [11:0] off_irq_status = 12'h014;
  // slot layout
  localparam int num_slots      = 12;
  localparam int slots_per_word = 4;
  localparam int slot_bits      = 8;
  localparam int en_pos         = 7;
  localparam int chan_width     = 5;
  localparam int slot_idx_w     = 4;
  // writable bits of one slot byte: enable and channel field
  localparam logic [7:0] slot_rw_mask = 8'h9f;
  localparam logic [31:0] word_reset  = 32'h0000_0000;
  // highest legal analog input code
  localparam logic [4:0] chan_max = 5'h11;
  // interrupt status bits
  localparam int irq_done_bit = 0;
  localparam int irq_bad_bit  = 1;
  localparam int irq_w        = 2;
  localparam logic [slot_idx_w-1:0] last_slot = 4'hb;
  // sequencer states
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_scan  = 2'b01,
    st_conv  = 2'b10,
    st_done  = 2'b11
  } seq_state_t;
endpackage

// File: design/slot_pick.sv
`timescale 1ns/100ps
// finds next enabled slot at or above a start index
module slot_pick (
  input  wire logic [adc_trig_pkg::num_slots-1:0]  enables,
  input  wire logic [adc_trig_pkg::slot_idx_w-1:0] start,
  output logic                                     found,
  output logic [adc_trig_pkg::slot_idx_w-1:0]      index
);
  // priority scan, lowest index first
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = adc_trig_pkg::num_slots - 1; i >= 0; i--) begin
      if (enables[i] && (i >= int'(start))) begin
        found = 1'b1;
        index = adc_trig_pkg::slot_idx_w'(i);
      end
    end
  end
endmodule

// File: sim/conv_core_model.sv
`timescale 1ns/100ps
// converter core stand-in: one completion pulse for every start pulse
module conv_core_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       conv_start,
  input  wire logic [3:0] delay,
  output logic            conv_complete
);
  int cnt = 0;

  // delay of zero answers the cycle after the start is seen; larger values model a slow core
  always @(posedge ref_clk) begin
    conv_complete <= 1'b0;
    if (!rst_n) begin
      cnt <= 0;
    end else if (conv_start) begin
      cnt <= int'(delay) + 1;
    end else if (cnt == 1) begin
      conv_complete <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: sim/tb.sv
`timescale 1ns/100ps
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig = 1'b0;
  logic        conv_start;
  logic [4:0]  analog_input;
  logic [3:0]  res_slot;
  logic        conv_complete;
  logic        done_irq;
  logic        irq;
  logic [3:0]  delay = 4'h0;
  logic [8:0]  seen_q[$];
  logic [8:0]  exp_q[$];
  logic [31:0] words[3];
  logic [31:0] rd;
  logic [31:0] w;
  logic [7:0]  sb;
  logic        err;
  logic        bad;
  logic        clk_en = 1'b1;
  int          seed = 93926;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          k;
  int          runs;
  int          n_done;

  adc_timer_trigger_slots i_adc_timer_trigger_slots (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trigger_event(trig), .conv_start(conv_start),
    .analog_input(analog_input), .conversion_result_slot(res_slot),
    .conv_complete(conv_complete), .timer_conversion_done_irq(done_irq), .irq(irq));

  conv_core_model i_conv_core_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .conv_start(conv_start), .delay(delay),
    .conv_complete(conv_complete));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // record every start the core is given, with its slot and input
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) seen_q.push_back({res_slot, analog_input});
  end

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; leading edge keeps release and next setup apart
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // gap bits of every slot byte never hold a written one
  function automatic logic [31:0] masked(input logic [31:0] v);
    return v & {4{adc_trig_pkg::slot_rw_mask}};
  endfunction

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 3; k++) begin
      apb(1'b0, adc_trig_pkg::off_word_0_3 + 12'(4 * k), 32'h0000_0000);
      check("reset word", rd, adc_trig_pkg::word_reset);
    end
    // unmapped place: error flagged, write dropped, reads zero
    apb(1'b1, 12'h018, 32'hffff_ffff);
    check("unmapped err", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h018, 32'h0000_0000);
    check("unmapped read", rd, 32'h0000_0000);
    // a trigger while frozen is lost: no done flag, sequencer still idle
    clk_en <= 1'b0;
    trig <= 1'b1;
    @(posedge ref_clk);
    trig <= 1'b0;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    apb(1'b0, adc_trig_pkg::off_irq_status, 32'h0000_0000);
    check("frozen trigger", rd, 32'h0000_0000);
    apb(1'b0, adc_trig_pkg::off_status, 32'h0000_0000);
    check("frozen state", rd, 32'h0000_0000);
    // round 0 all off, round 1 all on with a reserved code, then random;
    // round 5 sends a second trigger mid-sequence, which must be held
    for (int r = 0; r < 6; r++) begin
      exp_q.delete();
      seen_q.delete();
      bad = 1'b0;
      runs = (r == 5) ? 2 : 1;
      for (k = 0; k < 3; k++) begin
        w = (r == 0) ? 32'h0 : (r == 1) ? 32'hffff_ffff : $random(seed);
        words[k] = masked(w);
        apb(1'b1, adc_trig_pkg::off_word_0_3 + 12'(4 * k), w);
        apb(1'b0, adc_trig_pkg::off_word_0_3 + 12'(4 * k), 32'h0000_0000);
        check("slot word", rd, words[k]);
        check("slot err", {31'h0, err}, 32'h0000_0000);
      end
      for (k = 0; k < 12 * runs; k++) begin
        sb = words[(k % 12) / 4][8 * (k % 4) +: 8];
        if (sb[7]) exp_q.push_back({4'(k % 12), sb[4:0]});
        if (sb[7] && sb[4:0] > adc_trig_pkg::chan_max) bad = 1'b1;
      end
      delay <= 4'({$random(seed)} % 8);
      trig <= 1'b1;
      @(posedge ref_clk);
      trig <= 1'b0;
      if (runs == 2) begin
        @(posedge ref_clk);
        trig <= 1'b1;
        @(posedge ref_clk);
        trig <= 1'b0;
      end
      n_done = 0;
      for (k = 0; k < 600 && n_done < runs; k++) begin
        @(posedge ref_clk);
        if (done_irq === 1'b1) n_done++;
      end
      if (n_done < runs) begin
        error_cnt++;
        stop_test();
      end
      // the done pulse stands for one cycle only
      @(posedge ref_clk);
      check("done pulse", {31'h0, done_irq}, 32'h0000_0000);
      check("start count", 32'(seen_q.size()), 32'(exp_q.size()));
      foreach (exp_q[i]) begin
        if (i < seen_q.size()) check("slot input", 32'(seen_q[i]), 32'(exp_q[i]));
      end
      apb(1'b0, adc_trig_pkg::off_status, 32'h0000_0000);
      check("idle state", rd & 32'h0000_0003, 32'(adc_trig_pkg::st_idle));
      apb(1'b0, adc_trig_pkg::off_irq_status, 32'h0000_0000);
      check("irq status", rd, {30'h0, bad, 1'b1});
      // a mask bit of one lets its status bit through to the line
      apb(1'b1, adc_trig_pkg::off_irq_mask, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      check("irq masked", {31'h0, irq}, 32'h0000_0000);
      apb(1'b1, adc_trig_pkg::off_irq_mask, 32'h0000_0003);
      repeat (3) @(posedge ref_clk);
      check("irq unmasked", {31'h0, irq}, 32'h0000_0001);
      apb(1'b1, adc_trig_pkg::off_irq_status, 32'h0000_0003);
      repeat (3) @(posedge ref_clk);
      check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    end
    stop_test();
  end
endmodule
